// ### acc_regs.svh
// register offsets, field positions and reset values of the channel configuration bank
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ACC_ADDR_W          6
`define ACC_OFS_THRESH_HIGH 6'h07
`define ACC_OFS_THRESH_LOW  6'h08
`define ACC_OFS_CHANNEL0_CONFIG     6'h09
`define ACC_OFS_CH0_OCAL_HI 6'h0A
`define ACC_OFS_CH0_OCAL_LO 6'h0B
`define ACC_OFS_CH0_GCAL_HI 6'h0C
`define ACC_OFS_CH0_GCAL_LO 6'h0D
`define ACC_OFS_CHANNEL1_CONFIG     6'h0E

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACC_RST_ZERO        16'h0000
`define ACC_RST_GCAL_HI     16'h8000
`define ACC_RST_BYTE        8'h00
`define ACC_RST_RSVD3       3'h0
`define ACC_RST_COEFF       4'h0
`define ACC_RST_PHASE       10'h000
`define ACC_RST_MUX         2'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACC_CFG_PHASE_HI    15
`define ACC_CFG_PHASE_LO    6
`define ACC_CFG_HPOFF_BIT   2
`define ACC_CFG_MUX_HI      1
`define ACC_CFG_MUX_LO      0
`define ACC_UPPER_HI        15
`define ACC_UPPER_LO        8
`define ACC_COEFF_HI        3
`define ACC_COEFF_LO        0

// ----------------------------------------------------------------
// coefficient encodings
// ----------------------------------------------------------------
`define ACC_COEFF_BYPASS    4'h0
`define ACC_SHIFT_BASE      5'h01

`endif

// ### acc_pkg.sv
// types shared by the channel configuration bank
package acc_pkg;

	typedef enum logic [1:0]
	{
		ACC_MUX_EXT_PAIR = 2'h0,
		ACC_MUX_SHORTED  = 2'h1,
		ACC_MUX_TEST_POS = 2'h2,
		ACC_MUX_TEST_NEG = 2'h3
	} acc_mux_type;

	typedef struct packed
	{
		logic [9:0]  phase;
		logic        highpass_off;
		acc_mux_type input_select;
	} acc_chan_cfg_type;

	// what the datapath of one channel sees
	typedef struct packed
	{
		logic [9:0]  phase_delay;
		logic        highpass_en;
		logic [4:0]  highpass_shift;
		acc_mux_type input_select;
	} acc_chan_ctl_type;

	typedef struct packed
	{
		logic [15:0] thresh_high;
		logic [7:0]  thresh_low;
		logic [3:0]  coeff;
		acc_chan_cfg_type ch0;
		acc_chan_cfg_type ch1;
		logic [15:0] ocal_high;
		logic [7:0]  ocal_low;
		logic [15:0] gcal_high;
		logic [7:0]  gcal_low;
		logic [15:0] rdata;
	} acc_bank_state_type;

endpackage : acc_pkg

// ### acc_chan_ctl.sv
// per-channel filter control derived from global and channel settings
`timescale 1ns/1ps
`include "acc_regs.svh"

module acc_chan_ctl
	import acc_pkg::*;
(
	input  wire logic             CLK,
	input  wire logic             RST_N,
	input  wire logic [3:0]       coeff,
	input  wire acc_chan_cfg_type cfg,
	output acc_chan_ctl_type      ctl
);

	acc_chan_ctl_type state;
	acc_chan_ctl_type next_state;

	always_comb
	begin
		next_state = state;
		next_state.phase_delay  = cfg.phase;
		next_state.input_select = cfg.input_select;
		next_state.highpass_en  = (coeff != `ACC_COEFF_BYPASS) && !cfg.highpass_off;
		next_state.highpass_shift = {1'b0, coeff} + `ACC_SHIFT_BASE;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
			state <= '0;
		else
			state <= next_state;
	end

	assign ctl = state;

	chk_hp_off_wins: assert property (@(posedge CLK) disable iff (!RST_N)
		$past(cfg.highpass_off) |-> !ctl.highpass_en)
		else $error("filter enabled while channel disable set");

	chk_zero_bypass: assert property (@(posedge CLK) disable iff (!RST_N)
		($past(coeff) == `ACC_COEFF_BYPASS) |-> !ctl.highpass_en)
		else $error("filter enabled with zero coefficient code");

endmodule : acc_chan_ctl

// ### acc_cal_bank.sv
// channel calibration and configuration register bank with plain register port
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "acc_regs.svh"

// Overview of operation
// - threshold low byte in upper bits
// - threshold high word completes 24-bit value
// - coefficient codes halve from quarter downward
// - zero coefficient bypasses all channel filters
// - ten-bit signed phase delay top bits
// - channel disable bit turns filter off
// - two-bit input select routes converter input
// - offset high holds word bits 23:8
// - offset low byte in upper bits
// - gain high resets to 8000h
// - gain low byte upper, resets zero
// - channel 0 config at 9h
// - channel 1 config at Eh
// - channel 1 shares channel 0 layout

module acc_cal_bank
	import acc_pkg::*;
(
	input  wire logic [`ACC_ADDR_W-1:0] ADDR,
	input  wire logic [15:0]            WDATA,
	input  wire logic                   WR,
	input  wire logic                   RD,
	input  wire logic                   CLK,
	input  wire logic                   RST_N,
	output logic      [15:0]            RDATA,
	output logic      [23:0]            DETECT_THRESHOLD,
	output logic      [23:0]            CH0_OFFSET_CORR,
	output logic      [23:0]            CH0_GAIN_CORR,
	output acc_chan_ctl_type            CH0_CTL,
	output acc_chan_ctl_type            CH1_CTL
);

	acc_bank_state_type state;
	acc_bank_state_type next_state;

	// ----------------------------------------------------------------
	// register writes and read mux
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.rdata = `ACC_RST_ZERO;
		if (WR)
		begin
			case (ADDR)
				`ACC_OFS_THRESH_HIGH: next_state.thresh_high = WDATA;
				`ACC_OFS_THRESH_LOW:
				begin
					next_state.thresh_low = WDATA[`ACC_UPPER_HI:`ACC_UPPER_LO];
					next_state.coeff = WDATA[`ACC_COEFF_HI:`ACC_COEFF_LO];
				end
				`ACC_OFS_CHANNEL0_CONFIG:
				begin
					next_state.ch0.phase        = WDATA[`ACC_CFG_PHASE_HI:`ACC_CFG_PHASE_LO];
					next_state.ch0.highpass_off = WDATA[`ACC_CFG_HPOFF_BIT];
					next_state.ch0.input_select =
						acc_mux_type'(WDATA[`ACC_CFG_MUX_HI:`ACC_CFG_MUX_LO]);
				end
				`ACC_OFS_CH0_OCAL_HI: next_state.ocal_high = WDATA;
				`ACC_OFS_CH0_OCAL_LO: next_state.ocal_low = WDATA[`ACC_UPPER_HI:`ACC_UPPER_LO];
				`ACC_OFS_CH0_GCAL_HI: next_state.gcal_high = WDATA;
				`ACC_OFS_CH0_GCAL_LO: next_state.gcal_low = WDATA[`ACC_UPPER_HI:`ACC_UPPER_LO];
				`ACC_OFS_CHANNEL1_CONFIG:
				begin
					next_state.ch1.phase        = WDATA[`ACC_CFG_PHASE_HI:`ACC_CFG_PHASE_LO];
					next_state.ch1.highpass_off = WDATA[`ACC_CFG_HPOFF_BIT];
					next_state.ch1.input_select =
						acc_mux_type'(WDATA[`ACC_CFG_MUX_HI:`ACC_CFG_MUX_LO]);
				end
				default: ;
			endcase
		end
		// reserved bits are not stored, so software ignoring them does no harm
		// reserved writes dropped
		if (RD)
		begin
			case (ADDR)
				`ACC_OFS_THRESH_HIGH: next_state.rdata = state.thresh_high;
				`ACC_OFS_THRESH_LOW:
					next_state.rdata = {state.thresh_low, `ACC_RST_COEFF, state.coeff};
				`ACC_OFS_CHANNEL0_CONFIG:
					next_state.rdata = {state.ch0.phase, `ACC_RST_RSVD3,
						state.ch0.highpass_off, state.ch0.input_select};
				`ACC_OFS_CH0_OCAL_HI: next_state.rdata = state.ocal_high;
				`ACC_OFS_CH0_OCAL_LO: next_state.rdata = {state.ocal_low, `ACC_RST_BYTE};
				`ACC_OFS_CH0_GCAL_HI: next_state.rdata = state.gcal_high;
				`ACC_OFS_CH0_GCAL_LO: next_state.rdata = {state.gcal_low, `ACC_RST_BYTE};
				`ACC_OFS_CHANNEL1_CONFIG:
					next_state.rdata = {state.ch1.phase, `ACC_RST_RSVD3,
						state.ch1.highpass_off, state.ch1.input_select};
				// unmapped addresses read as zero
				default: next_state.rdata = `ACC_RST_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state              <= '0;
			state.gcal_high    <= `ACC_RST_GCAL_HI;
		end
		else
			state <= next_state;
	end

	// ----------------------------------------------------------------
	// assembled words, registered so outputs come from flip-flops
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			DETECT_THRESHOLD <= '0;
			CH0_OFFSET_CORR  <= '0;
			CH0_GAIN_CORR    <= {`ACC_RST_GCAL_HI, `ACC_RST_BYTE};
		end
		else
		begin
			DETECT_THRESHOLD <= {state.thresh_high, state.thresh_low};
			CH0_OFFSET_CORR  <= {state.ocal_high, state.ocal_low};
			CH0_GAIN_CORR    <= {state.gcal_high, state.gcal_low};
		end
	end

	assign RDATA = state.rdata;

	// ----------------------------------------------------------------
	// per-channel filter control
	// ----------------------------------------------------------------
	acc_chan_ctl u_ch0_ctl
	(
		.CLK   (CLK),
		.RST_N (RST_N),
		.coeff (state.coeff),
		.cfg   (state.ch0),
		.ctl   (CH0_CTL)
	);

	acc_chan_ctl u_ch1_ctl
	(
		.CLK   (CLK),
		.RST_N (RST_N),
		.coeff (state.coeff),
		.cfg   (state.ch1),
		.ctl   (CH1_CTL)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// low byte write then read
	chk_thr_low_read: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_THRESH_LOW) ##1 (RD && ADDR == `ACC_OFS_THRESH_LOW)
		|=> RDATA[`ACC_UPPER_HI:`ACC_UPPER_LO] == $past(WDATA[15:8], 2))
		else $error("threshold low byte readback wrong");

	chk_thr_assembly: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_THRESH_HIGH) |-> ##2 DETECT_THRESHOLD[23:8] == $past(WDATA, 2))
		else $error("threshold high word not in assembled value");

	chk_coeff_shift: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_THRESH_LOW && WDATA[3:0] == 4'h1)
		|-> ##2 CH0_CTL.highpass_shift == 5'h02)
		else $error("quarter coefficient shift wrong");

	chk_phase_field: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_CHANNEL0_CONFIG) |-> ##2 CH0_CTL.phase_delay == $past(WDATA[15:6], 2))
		else $error("channel 0 phase delay not taken");

	chk_mux_route: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_CHANNEL1_CONFIG) |-> ##2 CH1_CTL.input_select == $past(WDATA[1:0], 2))
		else $error("channel 1 input select not taken");

	chk_ocal_assembly: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_CH0_OCAL_LO) |-> ##2 CH0_OFFSET_CORR[7:0] == $past(WDATA[15:8], 2))
		else $error("offset low byte not in assembled word");

	chk_gcal_high: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_CH0_GCAL_HI) |-> ##2 CH0_GAIN_CORR[23:8] == $past(WDATA, 2))
		else $error("gain high word not in assembled word");

	chk_rsvd_zero: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && (ADDR == `ACC_OFS_CH0_OCAL_LO || ADDR == `ACC_OFS_CH0_GCAL_LO))
		|=> RDATA[7:0] == 8'h00)
		else $error("reserved calibration byte not zero");

	chk_cfg_rsvd: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && (ADDR == `ACC_OFS_CHANNEL0_CONFIG || ADDR == `ACC_OFS_CHANNEL1_CONFIG)) |=> RDATA[5:3] == 3'h0)
		else $error("reserved config bits not zero");

	chk_idle_rdata: assert property (@(posedge CLK) disable iff (!RST_N)
		!RD |=> RDATA == 16'h0000)
		else $error("read data not zero outside read answer");

	chk_ocal_high_read: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && ADDR == `ACC_OFS_CH0_OCAL_HI)
		|=> RDATA == CH0_OFFSET_CORR[23:8])
		else $error("offset high readback differs from assembled word");

	chk_ocal_low_read: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && ADDR == `ACC_OFS_CH0_OCAL_LO)
		|=> RDATA[15:8] == CH0_OFFSET_CORR[7:0])
		else $error("offset low readback differs from assembled word");

	chk_gcal_high_read: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && ADDR == `ACC_OFS_CH0_GCAL_HI)
		|=> RDATA == CH0_GAIN_CORR[23:8])
		else $error("gain high readback differs from assembled word");

	chk_gcal_low_read: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && ADDR == `ACC_OFS_CH0_GCAL_LO)
		|=> RDATA[15:8] == CH0_GAIN_CORR[7:0])
		else $error("gain low readback differs from assembled word");

	chk_thr_high_read: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && ADDR == `ACC_OFS_THRESH_HIGH)
		|=> RDATA == DETECT_THRESHOLD[23:8])
		else $error("threshold high readback differs from assembled value");

	chk_thr_low_mirror: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && ADDR == `ACC_OFS_THRESH_LOW)
		|=> RDATA[15:8] == DETECT_THRESHOLD[7:0])
		else $error("threshold low readback differs from assembled value");

	chk_thr_rsvd_zero: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && ADDR == `ACC_OFS_THRESH_LOW)
		|=> RDATA[7:4] == 4'h0)
		else $error("threshold reserved bits not zero");

	chk_unmapped_read: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD && (ADDR < `ACC_OFS_THRESH_HIGH || ADDR > `ACC_OFS_CHANNEL1_CONFIG))
		|=> RDATA == `ACC_RST_ZERO)
		else $error("unmapped address read not zero");

	chk_gain_reset: assert property (@(posedge CLK)
		(!RST_N ##1 !RST_N)
		|-> CH0_GAIN_CORR == {`ACC_RST_GCAL_HI, `ACC_RST_BYTE})
		else $error("gain word not at reset value during reset");

	chk_thr_reset: assert property (@(posedge CLK)
		(!RST_N ##1 !RST_N)
		|-> DETECT_THRESHOLD == {`ACC_RST_ZERO, `ACC_RST_BYTE})
		else $error("threshold not zero during reset");

	chk_ch0_reset: assert property (@(posedge CLK)
		(!RST_N ##1 !RST_N)
		|-> CH0_CTL.phase_delay == `ACC_RST_PHASE && CH0_CTL.input_select == ACC_MUX_EXT_PAIR)
		else $error("channel 0 control not at reset value");

	chk_ch1_reset: assert property (@(posedge CLK)
		(!RST_N ##1 !RST_N)
		|-> CH1_CTL.phase_delay == `ACC_RST_PHASE && CH1_CTL.input_select == ACC_MUX_EXT_PAIR)
		else $error("channel 1 control not at reset value");

	chk_ch0_mux: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_CHANNEL0_CONFIG)
		|-> ##2 CH0_CTL.input_select == $past(WDATA[1:0], 2))
		else $error("channel 0 input select not taken");

	chk_ch1_phase: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_CHANNEL1_CONFIG)
		|-> ##2 CH1_CTL.phase_delay == $past(WDATA[15:6], 2))
		else $error("channel 1 phase delay not taken");

	chk_ch1_hp_off: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_CHANNEL1_CONFIG && WDATA[`ACC_CFG_HPOFF_BIT])
		|-> ##2 !CH1_CTL.highpass_en)
		else $error("channel 1 filter enabled after disable write");

	chk_ch0_hp_follow: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_CHANNEL0_CONFIG && !WDATA[`ACC_CFG_HPOFF_BIT])
		|-> ##2 CH0_CTL.highpass_en == ($past(state.coeff) != `ACC_COEFF_BYPASS))
		else $error("channel 0 filter does not follow global code");

	chk_ch1_bypass: assert property (@(posedge CLK) disable iff (!RST_N)
		($past(state.coeff) == `ACC_COEFF_BYPASS)
		|-> !CH1_CTL.highpass_en)
		else $error("channel 1 filter enabled with zero coefficient code");

	chk_coeff_top: assert property (@(posedge CLK) disable iff (!RST_N)
		($past(state.coeff) == 4'hF)
		|-> CH0_CTL.highpass_shift == 5'h10)
		else $error("smallest coefficient shift wrong");

	chk_gcal_low_asm: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_CH0_GCAL_LO)
		|-> ##2 CH0_GAIN_CORR[7:0] == $past(WDATA[15:8], 2))
		else $error("gain low byte not in assembled word");

	chk_ocal_high_asm: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_CH0_OCAL_HI)
		|-> ##2 CH0_OFFSET_CORR[23:8] == $past(WDATA, 2))
		else $error("offset high word not in assembled word");

	chk_thr_low_asm: assert property (@(posedge CLK) disable iff (!RST_N)
		(WR && ADDR == `ACC_OFS_THRESH_LOW)
		|-> ##2 DETECT_THRESHOLD[7:0] == $past(WDATA[15:8], 2))
		else $error("threshold low byte not in assembled value");

endmodule : acc_cal_bank

// ### acc_host_model.sv
// host controller model that drives the register port of the bank
`timescale 1ns/1ps
`include "acc_regs.svh"

module acc_host_model
	import acc_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic [15:0]            rdata,
	output logic      [`ACC_ADDR_W-1:0] addr,
	output logic      [15:0]            wdata,
	output logic                        wr,
	output logic                        rd
);
	initial
	begin
		addr  = 6'h00;
		wdata = 16'h0000;
		wr    = 1'b0;
		rd    = 1'b0;
	end

	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	// reserved bits 5:3 of both channel config words forced zero
	task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
		addr  <= a;
		wdata <= ((a == `ACC_OFS_CHANNEL0_CONFIG) || (a == `ACC_OFS_CHANNEL1_CONFIG)) ? (d & 16'hFFC7) : d;
		wr    <= 1'b1;
		rd    <= 1'b0;
		@(posedge clk);
	endtask : wr_reg

	// data is taken at the edge closing the cycle after the strobe
	task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
		addr <= a;
		rd   <= 1'b1;
		wr   <= 1'b0;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask : rd_reg

	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : idle
endmodule : acc_host_model

// ### acc_cal_bank_tb_top.sv
// self-checking testbench of the channel configuration bank
`timescale 1ns/1ps

module acc_cal_bank_tb_top;
	import acc_pkg::*;

	logic             clk;
	logic             rst_n;
	logic [5:0]       addr;
	logic [15:0]      wdata;
	logic             wr;
	logic             rd;
	logic [15:0]      rdata;
	logic [23:0]      thr;
	logic [23:0]      ocal;
	logic [23:0]      gcal;
	acc_chan_ctl_type ctl0;
	acc_chan_ctl_type ctl1;
	logic [15:0]      rv;
	int               err_total;
	int               check_count;
	// ordinary cases: address, written value, value read back
	logic [5:0]  r_a[9] = '{6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h20};
	logic [15:0] r_w[9] = '{16'h1234, 16'hABFF, 16'hFFFF, 16'h5A5A, 16'h3CFF, 16'h1357,
		16'h99FF, 16'h8005, 16'hFFFF};
	logic [15:0] r_e[9] = '{16'h1234, 16'hAB0F, 16'hFFC7, 16'h5A5A, 16'h3C00, 16'h1357,
		16'h9900, 16'h8005, 16'h0000};

	acc_cal_bank u_acc_cal_bank (.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .CLK(clk),
		.RST_N(rst_n), .RDATA(rdata), .DETECT_THRESHOLD(thr), .CH0_OFFSET_CORR(ocal),
		.CH0_GAIN_CORR(gcal), .CH0_CTL(ctl0), .CH1_CTL(ctl1));
	acc_host_model u_acc_host_model (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if ((err_total == 0) && (check_count > 0))
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// hang guard
	initial
	begin
		repeat (5000) @(posedge clk);
		err_total++;
		close_out();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		err_total   = 0;
		check_count = 0;
		rst_n       = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			u_acc_host_model.rd_reg(6'h07 + 6'(i), rv);
			check({8'h00, rv}, (i == 5) ? 24'h008000 : 24'h000000, "reset read");
		end
		check(gcal, 24'h800000, "gain reset");
		check(24'(ctl0), {6'h00, 18'h00004}, "ctl reset");
		$display("test reset values done");
		for (int i = 0; i < 9; i++)
			u_acc_host_model.wr_reg(r_a[i], r_w[i]);
		for (int i = 0; i < 9; i++)
		begin
			u_acc_host_model.rd_reg(r_a[i], rv);
			check({8'h00, rv}, {8'h00, r_e[i]}, "table read");
		end
		@(posedge clk);
		check({8'h00, rdata}, 24'h000000, "read data lingers");
		check(thr, 24'h1234AB, "threshold word");
		check(ocal, 24'h5A5A3C, "offset word");
		check(gcal, 24'h135799, "gain word");
		check(24'(ctl0), 24'({10'h3FF, 1'b0, 5'h10, 2'h3}), "ch0 ctl");
		check(24'(ctl1), 24'({10'h200, 1'b0, 5'h10, 2'h1}), "ch1 ctl");
		$display("test table done");
		u_acc_host_model.wr_reg(6'h09, 16'h0000);
		for (int c = 0; c < 16; c++)
		begin
			u_acc_host_model.wr_reg(6'h08, {12'hAB0, 4'(c)});
			u_acc_host_model.rd_reg(6'h08, rv);
			check({8'h00, rv}, {8'h00, 8'hAB, 4'h0, 4'(c)}, "coeff read");
			check(24'(ctl0), 24'({10'h000, c != 0, 5'(c + 1), 2'h0}), "coeff");
		end
		$display("test coefficients done");
		for (int m = 0; m < 4; m++)
		begin
			u_acc_host_model.wr_reg(6'h0E, {10'h001, 3'h0, 1'b0, 2'(m)});
			u_acc_host_model.idle(2);
			check(24'(ctl1), 24'({10'h001, 1'b1, 5'h10, 2'(m)}), "mux");
		end
		$display("test input select done");
		rst_n <= 1'b0;
		u_acc_host_model.idle(2);
		check(gcal, 24'h800000, "gain mid reset");
		check(thr, 24'h000000, "threshold mid reset");
		rst_n <= 1'b1;
		@(posedge clk);
		u_acc_host_model.rd_reg(6'h0C, rv);
		check({8'h00, rv}, 24'h008000, "gain after reset");
		u_acc_host_model.rd_reg(6'h0E, rv);
		check({8'h00, rv}, 24'h000000, "ch1 after reset");
		$display("test mid reset done");
		close_out();
	end
endmodule : acc_cal_bank_tb_top
